// [tpc_bank.sv]
// transmit-path control bank behind a 2-wire serial slave
`timescale 1ns/100ps
module tpc_bank #(
    parameter logic [6:0] DEV_ADDR    = tpc_pkg::DEV_ADDR_DFLT,
    parameter int         LOCK_CYCLES = tpc_pkg::LOCK_CYCLES
) (
    // clock and reset
    input  wire logic           ref_clk_i,
    input  wire logic           reset_i,
    // 2-wire serial interface
    input  wire logic           scl_i,
    input  wire logic           sda_i,
    output logic                sda_o,
    output logic                sda_oe_o,
    // receive-path bank and analog status
    input  wire logic           rx_recovery_bypass_i,
    input  wire logic           tx_signal_present_i,
    input  wire logic           tx_rate_found_i,
    // transmit-path settings
    output tpc_pkg::tpc_tx_ctl_s tx_ctl_o,
    output logic                tx_lock_late_o
);
    import tpc_pkg::*;

    // ----------------------------------------
    // input synchronisation
    // ----------------------------------------
    logic [3:0] sync_w;
    logic       scl_s;
    logic       sda_s;
    logic       sig_s;
    logic       found_s;

    tpc_sync #(
        .WIDTH (4)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .async_i   ({scl_i, sda_i, tx_signal_present_i, tx_rate_found_i}),
        .sync_o    (sync_w)
    );

    assign {scl_s, sda_s, sig_s, found_s} = sync_w;
    logic scl_q_ff;
    logic sda_q_ff;
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end
        else
        begin
            scl_q_ff <= scl_s;
            sda_q_ff <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    assign scl_rise   = scl_s & ~scl_q_ff;
    assign scl_fall   = ~scl_s & scl_q_ff;
    assign start_seen = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
    assign stop_seen  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    // returns {hit, index}; shared by write and read paths
    function automatic logic [3:0] reg_index(input logic [7:0] ofs);
        logic [3:0] r;
        r = 4'h0;
        case (ofs)
            OFS_TX_PATH_CONTROL:  r = 4'h8;
            OFS_TX_EQUALIZER:     r = 4'h9;
            OFS_TX_OUTPUT_DRIVER: r = 4'ha;
            OFS_TX_RECOVERY_DET:  r = 4'hb;
            OFS_RECOVERY_LOOP_BW: r = 4'hc;
            default:              r = 4'h0;
        endcase
        return r;
    endfunction

    logic [7:0] regs_ff [NUM_REGS];
    logic [7:0] ptr_ff;
    logic [3:0] ptr_dec;
    assign ptr_dec = reg_index(ptr_ff);

    // ----------------------------------------
    // 2-wire slave
    // ----------------------------------------
    tpc_tw_e    tw_ff;
    logic [7:0] shift_ff;
    logic [3:0] bits_ff;
    logic       rd_ff;
    logic       nack_ff;
    logic       drive_ff;
    logic       wr_stb;

    assign wr_stb = scl_fall && (tw_ff == TW_WRDATA) && (bits_ff == BITS_PER_BYTE);

    // open drain: only ever pulls low
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            tw_ff    <= TW_IDLE;
            shift_ff <= 8'h00;
            bits_ff  <= 4'h0;
            rd_ff    <= 1'b0;
            nack_ff  <= 1'b0;
            drive_ff <= 1'b0;
            ptr_ff   <= 8'h00;
        end
        else if (start_seen)
        begin
            tw_ff    <= TW_DEVADR;
            bits_ff  <= 4'h0;
            drive_ff <= 1'b0;
        end
        else if (stop_seen)
        begin
            tw_ff    <= TW_IDLE;
            drive_ff <= 1'b0;
        end
        else if (scl_rise)
        begin
            case (tw_ff)
                TW_DEVADR, TW_REGPTR, TW_WRDATA:
                begin
                    shift_ff <= {shift_ff[6:0], sda_s};
                    bits_ff  <= bits_ff + 4'h1;
                end
                TW_RDDATA: bits_ff <= bits_ff + 4'h1;
                TW_RDACK:  nack_ff <= sda_s;
                default:   bits_ff <= bits_ff;
            endcase
        end
        else if (scl_fall)
        begin
            case (tw_ff)
                TW_DEVADR:
                begin
                    if (bits_ff == BITS_PER_BYTE)
                    begin
                        if (shift_ff[7:1] == DEV_ADDR)
                        begin
                            tw_ff    <= TW_ACKADR;
                            rd_ff    <= shift_ff[0];
                            drive_ff <= 1'b1;
                        end
                        else
                        begin
                            tw_ff <= TW_IDLE;
                        end
                    end
                end
                TW_REGPTR:
                begin
                    if (bits_ff == BITS_PER_BYTE)
                    begin
                        ptr_ff   <= shift_ff;
                        tw_ff    <= TW_ACKPTR;
                        drive_ff <= 1'b1;
                    end
                end
                TW_WRDATA:
                begin
                    if (bits_ff == BITS_PER_BYTE)
                    begin
                        ptr_ff   <= ptr_ff + 8'h01;
                        tw_ff    <= TW_ACKWR;
                        drive_ff <= 1'b1;
                    end
                end
                TW_ACKADR, TW_ACKPTR, TW_ACKWR, TW_RDACK:
                begin
                    bits_ff <= 4'h0;
                    if ((tw_ff == TW_ACKADR && rd_ff) || (tw_ff == TW_RDACK && !nack_ff))
                    begin
                        // read data, pointer steps per byte
                        shift_ff <= ptr_dec[3] ? regs_ff[ptr_dec[2:0]] : READ_UNMAPPED;
                        drive_ff <= ptr_dec[3] ? ~regs_ff[ptr_dec[2:0]][7] : ~READ_UNMAPPED[7];
                        ptr_ff   <= ptr_ff + 8'h01;
                        tw_ff    <= TW_RDDATA;
                    end
                    else if (tw_ff == TW_RDACK)
                    begin
                        drive_ff <= 1'b0;
                        tw_ff    <= TW_IDLE;
                    end
                    else
                    begin
                        drive_ff <= 1'b0;
                        tw_ff    <= (tw_ff == TW_ACKADR) ? TW_REGPTR : TW_WRDATA;
                    end
                end
                TW_RDDATA:
                begin
                    if (bits_ff == BITS_PER_BYTE)
                    begin
                        drive_ff <= 1'b0;
                        tw_ff    <= TW_RDACK;
                    end
                    else
                    begin
                        shift_ff <= {shift_ff[6:0], 1'b0};
                        drive_ff <= ~shift_ff[6];
                    end
                end
                default: tw_ff <= TW_IDLE;
            endcase
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = drive_ff;

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    // unmapped offsets are acknowledged but not stored
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                regs_ff[i] <= REG_RESET;
            end
        end
        else if (wr_stb && ptr_dec[3])
        begin
            regs_ff[ptr_dec[2:0]] <= shift_ff;
        end
    end

    logic [7:0] r_path;
    logic [7:0] r_eq;
    logic [7:0] r_drv;
    logic [7:0] r_det;
    logic [7:0] r_bw;

    assign r_path = regs_ff[0];
    assign r_eq   = regs_ff[1];
    assign r_drv  = regs_ff[2];
    assign r_det  = regs_ff[3];
    assign r_bw   = regs_ff[4];

    // ----------------------------------------
    // frequency detector sequencing
    // ----------------------------------------
    tpc_fd_e               fd_ff;
    logic [LOCK_CNT_W-1:0] lock_cnt_ff;

    // runs in every mode; forcing bits override tx_detector_on below, but not the late-lock flag
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            fd_ff <= FD_IDLE;
        end
        else
        begin
            case (fd_ff)
                FD_IDLE:   fd_ff <= sig_s ? FD_SEARCH : FD_IDLE;
                FD_SEARCH:
                begin
                    if (!sig_s)
                    begin
                        fd_ff <= FD_IDLE;
                    end
                    else if (found_s)
                    begin
                        fd_ff <= FD_FOUND;
                    end
                end
                FD_FOUND:  fd_ff <= sig_s ? FD_FOUND : FD_IDLE;
                default:   fd_ff <= FD_IDLE;
            endcase
        end
    end

    // flags a fast-lock search that overruns its lock time
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            lock_cnt_ff    <= '0;
            tx_lock_late_o <= 1'b0;
        end
        else if (fd_ff != FD_SEARCH || r_det[BIT_FAST_OFF])
        begin
            lock_cnt_ff    <= '0;
            tx_lock_late_o <= 1'b0;
        end
        else if (lock_cnt_ff == LOCK_CNT_W'(LOCK_CYCLES))
        begin
            tx_lock_late_o <= 1'b1;
        end
        else
        begin
            lock_cnt_ff <= lock_cnt_ff + 1'b1;
        end
    end

    // ----------------------------------------
    // settings to the analog path
    // ----------------------------------------
    tpc_tx_ctl_s nxt_ctl;
    tpc_tx_ctl_s ctl_ff;
    logic        se;
    logic        neg;

    always_comb
    begin
        se  = r_drv[BIT_SINGLE_END];
        neg = r_drv[BIT_NEG_SELECT];
        nxt_ctl = '0;
        nxt_ctl.tx_equalizer_off      = r_path[BIT_EQ_OFF];
        nxt_ctl.tx_equalizer_strength = r_eq[LSB_EQ_STRENGTH +: 4];
        nxt_ctl.tx_recovery_off       = r_path[BIT_REC_OFF];
        nxt_ctl.tx_recovery_bypassed  = r_path[BIT_REC_OFF]
            | (r_path[BIT_REC_BYPASS] & rx_recovery_bypass_i);
        nxt_ctl.loop_bandwidth_select = r_bw[LSB_LOOP_BW +: 3];
        nxt_ctl.tx_retimer_divider    = r_det[LSB_DIVIDER +: 3];
        nxt_ctl.tx_fast_lock_on       = ~r_det[BIT_FAST_OFF];
        nxt_ctl.tx_detector_rate_preset = r_det[LSB_RATE_PRESET +: 2];
        if (r_det[BIT_DET_OFF])
        begin
            nxt_ctl.tx_detector_on = 1'b0;
        end
        else if (r_det[BIT_DET_ON])
        begin
            nxt_ctl.tx_detector_on = 1'b1;
        end
        else
        begin
            nxt_ctl.tx_detector_on = (fd_ff == FD_SEARCH);
        end
        nxt_ctl.tx_output_invert       = r_path[BIT_OUT_INVERT];
        nxt_ctl.tx_driver_off          = r_path[BIT_DRIVER_OFF];
        nxt_ctl.tx_single_ended_select = se;
        nxt_ctl.tx_pos_output_on = ~r_path[BIT_DRIVER_OFF] & (~se | ~neg);
        nxt_ctl.tx_neg_output_on = ~r_path[BIT_DRIVER_OFF] & (~se | neg);
        nxt_ctl.tx_deemphasis_strength = r_drv[LSB_DEEMPH +: 4];
        nxt_ctl.tx_peaking_wide        = r_eq[BIT_PEAK_WIDE];
        nxt_ctl.tx_deemphasis_delayed  = r_drv[BIT_DEEMPH_DLY];
        nxt_ctl.tx_slow_edges          = r_drv[BIT_SLOW_EDGES];
    end

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ctl_ff <= '0;
        end
        else
        begin
            ctl_ff <= nxt_ctl;
        end
    end
    assign tx_ctl_o = ctl_ff;

endmodule

// [tpc_pkg.sv]
// constants, types and field layout of the transmit-path control bank
// What this block does
// - tx_equalizer_off, bit 1 of tx_path_control, bypasses the equalizer; on after reset.
// - tx_equalizer_strength, four bits of tx_equalizer_setting, sets equalization amount.
// - tx_recovery_off, bit 4 of tx_path_control, powers down and bypasses recovery.
// - tx_recovery_bypass, bit 3, bypasses recovery only if rx_recovery_bypass is set.
// - loop_bandwidth_select, bits 5-7 of recovery_loop_bandwidth, sets both loop bandwidths.
// - after reset the detector is automatic, searching once a transmit signal appears.
// - fast lock within 2 ms by default; tx_fast_lock_off, bit 3, disables it.
// - automatic mode switches the detector off once the rate is found.
// - tx_detector_force_on, bit 5 of tx_recovery_detector_setting, keeps detector running unless bit 4 is set.
// - tx_detector_force_off, bit 4 of tx_recovery_detector_setting, holds detector off.
// - tx_detector_rate_preset, bits 6-7, presets one of two fixed rates.
// - tx_retimer_divider, bits 0-2; host uses divide-by-4 at 2.5 Gbps.
// - tx_output_invert, bit 5 of tx_path_control, inverts the output pair.
// - tx_driver_off, bit 6 of tx_path_control, disables the output driver.
// - differential after reset; tx_single_ended_select, bit 6 of tx_output_driver_setting.
// - single-ended uses positive output; tx_negative_output_select, bit 7, swaps.
// - tx_deemphasis_strength, bits 0-3, sets de-emphasis amount.
// - tx_peaking_wide, bit 6 of tx_equalizer_setting, widens the de-emphasis pulse.
// - tx_deemphasis_delayed, bit 5, delays de-emphasis.
// - tx_slow_edges, bit 4 of tx_output_driver_setting; set below modulation 0xC0.
// - all control registers are written and read over the 2-wire interface.
package tpc_pkg;

    // ----------------------------------------
    // register offsets and reset values
    // ----------------------------------------
    localparam logic [7:0] OFS_TX_PATH_CONTROL   = 8'h0a;
    localparam logic [7:0] OFS_TX_EQUALIZER      = 8'h0b;
    localparam logic [7:0] OFS_TX_OUTPUT_DRIVER  = 8'h0d;
    localparam logic [7:0] OFS_TX_RECOVERY_DET   = 8'h13;
    localparam logic [7:0] OFS_RECOVERY_LOOP_BW  = 8'h33;
    localparam int         NUM_REGS              = 5;
    localparam logic [7:0] REG_RESET             = 8'h00;
    localparam logic [7:0] READ_UNMAPPED         = 8'h00;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_EQ_OFF      = 1;
    localparam int BIT_REC_BYPASS  = 3;
    localparam int BIT_REC_OFF     = 4;
    localparam int BIT_OUT_INVERT  = 5;
    localparam int BIT_DRIVER_OFF  = 6;
    localparam int LSB_EQ_STRENGTH = 0;
    localparam int BIT_PEAK_WIDE   = 6;
    localparam int LSB_DEEMPH      = 0;
    localparam int BIT_SLOW_EDGES  = 4;
    localparam int BIT_DEEMPH_DLY  = 5;
    localparam int BIT_SINGLE_END  = 6;
    localparam int BIT_NEG_SELECT  = 7;
    localparam int LSB_DIVIDER     = 0;
    localparam int BIT_FAST_OFF    = 3;
    localparam int BIT_DET_OFF     = 4;
    localparam int BIT_DET_ON      = 5;
    localparam int LSB_RATE_PRESET = 6;
    localparam int LSB_LOOP_BW     = 5;

    // ----------------------------------------
    // timing and 2-wire framing
    // ----------------------------------------
    localparam int         CLK_KHZ        = 20000;
    localparam int         LOCK_TIME_US   = 2000;
    localparam int         LOCK_CYCLES    = LOCK_TIME_US * CLK_KHZ / 1000;
    localparam int         LOCK_CNT_W     = 20;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam logic [6:0] DEV_ADDR_DFLT  = 7'h50; // bus address, value arbitrary

    typedef enum logic [8:0] {
        TW_IDLE   = 9'b0_0000_0001,
        TW_DEVADR = 9'b0_0000_0010,
        TW_ACKADR = 9'b0_0000_0100,
        TW_REGPTR = 9'b0_0000_1000,
        TW_ACKPTR = 9'b0_0001_0000,
        TW_WRDATA = 9'b0_0010_0000,
        TW_ACKWR  = 9'b0_0100_0000,
        TW_RDDATA = 9'b0_1000_0000,
        TW_RDACK  = 9'b1_0000_0000
    } tpc_tw_e;

    typedef enum logic [2:0] {
        FD_IDLE   = 3'b001,
        FD_SEARCH = 3'b010,
        FD_FOUND  = 3'b100
    } tpc_fd_e;

    // settings handed to the analog transmit path
    typedef struct packed {
        logic       tx_equalizer_off;
        logic [3:0] tx_equalizer_strength;
        logic       tx_recovery_off;
        logic       tx_recovery_bypassed;
        logic [2:0] loop_bandwidth_select;
        logic [2:0] tx_retimer_divider;
        logic       tx_fast_lock_on;
        logic [1:0] tx_detector_rate_preset;
        logic       tx_detector_on;
        logic       tx_output_invert;
        logic       tx_driver_off;
        logic       tx_single_ended_select;
        logic       tx_pos_output_on;
        logic       tx_neg_output_on;
        logic [3:0] tx_deemphasis_strength;
        logic       tx_peaking_wide;
        logic       tx_deemphasis_delayed;
        logic       tx_slow_edges;
    } tpc_tx_ctl_s;

endpackage

// [tpc_sync.sv]
// two-flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
module tpc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             reset_i,
    // levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule

// [tpc_host.sv]
// 2-wire host controller model: drives the clock and pulls the data line
`timescale 1ns/100ps
module tpc_host (
    // bus pins
    output logic      scl_o,
    output logic      sda_pull_o,
    input  wire logic sda_i
);
    // ----------------------------------------
    // bit and frame timing
    // ----------------------------------------
    int gap = 0;

    // clock stands high between frames
    initial
    begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    // data moves mid-low so no false start or stop is seen
    task automatic bit_io(input logic b, output logic r);
        #(100 + gap) sda_pull_o = ~b;
        #100 scl_o = 1'b1;
        #(100 + gap) r = sda_i;
        #100 scl_o = 1'b0;
    endtask

    task automatic start_cond();
        #100 sda_pull_o = 1'b0;
        #100 scl_o = 1'b1;
        #100 sda_pull_o = 1'b1;
        #100 scl_o = 1'b0;
    endtask

    task automatic stop_cond();
        #100 sda_pull_o = 1'b1;
        #100 scl_o = 1'b1;
        #100 sda_pull_o = 1'b0;
        #500;
    endtask

    // msb first, then the acknowledge slot
    task automatic byte_io(input logic [7:0] d, input logic ai,
                           output logic [7:0] q, output logic ak);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(ai, ak);
    endtask

    // one register access; ok is low if any byte the host sent went unacknowledged
    task automatic xfer(input logic [6:0] dev, input logic [7:0] ofs, input logic rd,
                        inout logic [7:0] data, output logic ok);
        logic [7:0] q;
        logic       a0, a1, a2, a3;
        start_cond();
        byte_io({dev, 1'b0}, 1'b1, q, a0);
        byte_io(ofs, 1'b1, q, a1);
        a2 = 1'b0;
        a3 = 1'b0;
        if (rd)
        begin
            start_cond();
            byte_io({dev, 1'b1}, 1'b1, q, a2);
            byte_io(8'hff, 1'b1, data, q[0]);
        end
        else
            byte_io(data, 1'b1, q, a3);
        stop_cond();
        ok = ~(a0 | a1 | a2 | a3);
    endtask
endmodule

// [tpc_bank_chk.sv]
// port-level checks for the transmit-path control bank
`timescale 1ns/100ps
module tpc_bank_chk #(
    parameter int LOCK_CYCLES = tpc_pkg::LOCK_CYCLES
) (
    // clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 reset_i,
    // 2-wire pins
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    input  wire logic                 sda_o,
    input  wire logic                 sda_oe_o,
    // status and settings
    input  wire logic                 rx_recovery_bypass_i,
    input  wire logic                 tx_signal_present_i,
    input  wire logic                 tx_rate_found_i,
    input  wire tpc_pkg::tpc_tx_ctl_s tx_ctl_o,
    input  wire logic                 tx_lock_late_o
);
    import tpc_pkg::*;
    // ----------------------------------------
    // helper: outputs show decode from third edge on
    // ----------------------------------------
    logic [1:0] age_ff;
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            age_ff <= 2'h0;
        else if (age_ff != 2'h3)
            age_ff <= age_ff + 2'h1;
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    a_driver_off_quiet : assert property (
        tx_ctl_o.tx_driver_off |-> !tx_ctl_o.tx_pos_output_on && !tx_ctl_o.tx_neg_output_on)
        else $error("outputs on while driver off");
    a_diff_both_on : assert property (
        age_ff == 2'h3 && !tx_ctl_o.tx_driver_off && !tx_ctl_o.tx_single_ended_select
        |-> tx_ctl_o.tx_pos_output_on && tx_ctl_o.tx_neg_output_on)
        else $error("differential mode lost an output");
    a_single_one_side : assert property (
        !tx_ctl_o.tx_driver_off && tx_ctl_o.tx_single_ended_select
        |-> tx_ctl_o.tx_pos_output_on != tx_ctl_o.tx_neg_output_on)
        else $error("single-ended mode drives both or neither");
    a_off_bypasses : assert property (
        tx_ctl_o.tx_recovery_off |-> tx_ctl_o.tx_recovery_bypassed)
        else $error("recovery off but not bypassed");
    a_rx_gates_bypass : assert property (
        !tx_ctl_o.tx_recovery_off && !$past(rx_recovery_bypass_i)
        && !$past(rx_recovery_bypass_i, 2) |-> !tx_ctl_o.tx_recovery_bypassed)
        else $error("bypass without receive bypass");
    a_sda_low_only : assert property (
        sda_o == 1'b0)
        else $error("data pin driven high");
    a_oe_scl_low : assert property (
        $changed(sda_oe_o) |-> !scl_i)
        else $error("data changed while clock high");
    a_lock_late_cause : assert property (
        $rose(tx_lock_late_o) |-> tx_ctl_o.tx_fast_lock_on && $past(tx_ctl_o.tx_detector_on, 8))
        else $error("late lock flag without fast search");
endmodule

bind tpc_bank tpc_bank_chk #(.LOCK_CYCLES(LOCK_CYCLES)) chk (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .rx_recovery_bypass_i(rx_recovery_bypass_i),
    .tx_signal_present_i(tx_signal_present_i), .tx_rate_found_i(tx_rate_found_i),
    .tx_ctl_o(tx_ctl_o), .tx_lock_late_o(tx_lock_late_o)
);

// [tpc_bank_test.sv]
// self-checking bench for the transmit-path control bank
`timescale 1ns/100ps
module tpc_bank_test;
    import tpc_pkg::*;
    localparam int LOCK_SIM = 100;
    localparam logic [7:0] OFS [5] = '{OFS_TX_PATH_CONTROL, OFS_TX_EQUALIZER,
        OFS_TX_OUTPUT_DRIVER, OFS_TX_RECOVERY_DET, OFS_RECOVERY_LOOP_BW};
    localparam logic [7:0] PAT [4][5] = '{'{8'h2a, 8'h4f, 8'h7c, 8'h6c, 8'he0},
        '{8'h0a, 8'h0a, 8'hc3, 8'hb3, 8'h35}, '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff},
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00}};
    logic        clk = 1'b0;
    logic        reset_i = 1'b1;
    logic        scl, pull, sda_w, sda_o, sda_oe, rxb, sig, found, late;
    tpc_tx_ctl_s ctl;
    logic [7:0]  sh [5] = '{default: 8'h00};
    int          fails = 0;
    int          samples_checked = 0;

    always #25 clk = ~clk;
    // pull-up unless a party pulls low
    assign sda_w = ~(pull | (sda_oe & ~sda_o));

    tpc_bank #(.LOCK_CYCLES(LOCK_SIM)) dut (
        .ref_clk_i(clk), .reset_i(reset_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .rx_recovery_bypass_i(rxb), .tx_signal_present_i(sig),
        .tx_rate_found_i(found), .tx_ctl_o(ctl), .tx_lock_late_o(late));
    tpc_host host (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda_w));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic give_verdict();
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask

    // leaves time one step past a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d,
                      input logic ack);
        logic ok;
        host.xfer(dev, ofs, 1'b0, d, ok);
        check("write ack", 32'(ok), 32'(ack));
    endtask

    task automatic rd(input logic [7:0] ofs, input logic [7:0] want);
        logic [7:0] d;
        logic       ok;
        d = 8'h00;
        host.xfer(DEV_ADDR_DFLT, ofs, 1'b1, d, ok);
        check("read ack", 32'(ok), 32'(1'b1));
        check("read data", 32'(d), 32'(want));
    endtask

    // detector idle: only the forcing bits decide it
    function automatic tpc_tx_ctl_s exp_ctl(input logic rx);
        tpc_tx_ctl_s e;
        e = '0;
        e.tx_equalizer_off = sh[0][1];
        e.tx_equalizer_strength = sh[1][3:0];
        e.tx_recovery_off = sh[0][4];
        e.tx_recovery_bypassed = sh[0][4] | (sh[0][3] & rx);
        e.loop_bandwidth_select = sh[4][7:5];
        e.tx_retimer_divider = sh[3][2:0];
        e.tx_fast_lock_on = ~sh[3][3];
        e.tx_detector_rate_preset = sh[3][7:6];
        e.tx_detector_on = sh[3][5] & ~sh[3][4];
        e.tx_output_invert = sh[0][5];
        e.tx_driver_off = sh[0][6];
        e.tx_single_ended_select = sh[2][6];
        e.tx_pos_output_on = ~sh[0][6] & ~(sh[2][6] & sh[2][7]);
        e.tx_neg_output_on = ~sh[0][6] & ~(sh[2][6] & ~sh[2][7]);
        e.tx_deemphasis_strength = sh[2][3:0];
        e.tx_peaking_wide = sh[1][6];
        e.tx_deemphasis_delayed = sh[2][5];
        e.tx_slow_edges = sh[2][4];
        return e;
    endfunction

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        {rxb, sig, found} = 3'h0;
        tick(6);
        reset_i = 1'b0;
        tick(3);
        check("reset settings", 32'(ctl), 32'(exp_ctl(1'b0)));
        for (int k = 0; k < 5; k++)
            rd(OFS[k], REG_RESET);
        for (int p = 0; p < 4; p++)
        begin
            rxb = p[0];
            host.gap = (p == 2) ? 200 : 0;
            for (int k = 0; k < 5; k++)
            begin
                sh[k] = PAT[p][k];
                wr(DEV_ADDR_DFLT, OFS[k], sh[k], 1'b1);
            end
            tick(4);
            check("settings", 32'(ctl), 32'(exp_ctl(rxb)));
            for (int k = 0; k < 5; k++)
                rd(OFS[k], sh[k]);
        end
        wr(7'h51, OFS[0], 8'h55, 1'b0);
        rd(OFS[0], 8'h00);
        wr(DEV_ADDR_DFLT, 8'h20, 8'h55, 1'b1);
        rd(8'h20, READ_UNMAPPED);
        sig = 1'b1;
        tick(10);
        check("search", 32'(ctl.tx_detector_on), 32'(1'b1));
        tick(LOCK_SIM + 10);
        check("lock late", 32'(late), 32'(1'b1));
        found = 1'b1;
        tick(10);
        check("found", 32'(ctl.tx_detector_on), 32'(1'b0));
        wr(DEV_ADDR_DFLT, OFS[3], 8'h20, 1'b1);
        check("forced on", 32'(ctl.tx_detector_on), 32'(1'b1));
        wr(DEV_ADDR_DFLT, OFS[3], 8'h30, 1'b1);
        check("forced off", 32'(ctl.tx_detector_on), 32'(1'b0));
        {reset_i, sig, found} = 3'h4;
        tick(2);
        reset_i = 1'b0;
        tick(3);
        rd(OFS[3], REG_RESET);
        wr(DEV_ADDR_DFLT, OFS[3], 8'h08, 1'b1);
        sig = 1'b1;
        tick(LOCK_SIM + 20);
        check("slow search", 32'(ctl.tx_detector_on), 32'(1'b1));
        check("no late flag", 32'(late), 32'(1'b0));
        give_verdict();
    end

    // run needs about 0.9 ms
    initial
    begin
        #3000000;
        fails++;
        give_verdict();
    end
endmodule
